// ===== core/aidr_module.sv
// analog input module end: function codes, scaling, diagnostic record
// assumes measured millivolts and fault inputs arrive on core_clk
//
// Overview of operation
// - per-channel function code, reset 10h, FFh off
// - code 10h: 10 V gives 27648
// - code 20h: 10 V gives 16384
// - channel errors light channel LED; all errors light module LED and record
// - no interrupt; diagnostics only by reading
// - detect config, overflow, underflow per channel
// - record 01h full, 00h first four
// - index 2F01h full, 2F00h first four
// - index 5005h, subindex from 02h per byte
// - function codes via 80h/81h, 3100h/3101h, 01h/02h
// - summary byte fault bits
// - module information byte reads 15h
// - constant kind, bit count, channel count bytes
// - fixed record byte order, errors reset zero
// - internal byte: buffer overflow, comm error
// - channel summary bit per channel
// - channel byte: config, underflow, overflow bits
// - timestamp captures microsecond ticker on event
`timescale 1ns/1ps
`default_nettype none
module aidr_module
   import aidr_pkg::*;
(
   input  wire logic                   core_clk,
   input  wire logic                   rst,
   aidr_link_if.dev                    link,
   input  wire logic signed [15:0]     volt_mv [NUM_CHAN],
   input  wire logic                   module_fail,
   input  wire logic                   aux_supply_missing,
   input  wire logic                   diag_buf_overflow,
   input  wire logic                   int_comm_error,
   output logic        [15:0]          chan_code [NUM_CHAN],
   output logic        [7:0]           chan_function_code [NUM_CHAN],
   output logic        [NUM_CHAN-1:0]  chan_err_led,
   output logic                        module_err_led
);
   logic [7:0]          fn_reg [NUM_CHAN];
   logic [15:0]         code_reg [NUM_CHAN];
   logic [NUM_CHAN-1:0] over_reg;
   logic [NUM_CHAN-1:0] under_reg;
   logic [NUM_CHAN-1:0] cfg_reg;
   logic [7:0]          summary;
   logic [7:0]          intern;
   logic [7:0]          summary_prev_reg;
   logic [31:0]         us_count_reg;
   logic [$clog2(CYC_PER_US)-1:0] us_div_reg;
   logic [31:0]         stamp_reg;
   logic [7:0]          rec [REC_BYTES];

   // per-channel scaling and range checks
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CHAN; ch++)
      begin : g_chan
         logic signed [34:0] prod;
         logic signed [18:0] scaled;
         logic signed [18:0] nom_hi;
         logic signed [18:0] ovr_lim;
         logic signed [18:0] und_lim;
         logic               fn_s7;
         logic               fn_s5;
         always_comb
         begin
            fn_s7  = (fn_reg[ch] == FN_S7_RANGE);
            fn_s5  = (fn_reg[ch] == FN_S5_RANGE);
            prod   = 35'(volt_mv[ch] * $signed({1'b0, fn_s5 ? S5_SCALE : S7_SCALE}));
            scaled = prod[34:16];
            nom_hi  = fn_s5 ? 19'(S5_NOM_HI) : 19'(S7_NOM_HI);
            ovr_lim = fn_s5 ? 19'(S5_OVR_LIM) : 19'(S7_OVR_LIM);
            und_lim = fn_s5 ? 19'(S5_UND_LIM) : 19'(S7_UND_LIM);
         end

         always_ff @(posedge core_clk or posedge rst)
         begin
            if (rst)
            begin
               code_reg[ch]  <= 16'h0000;
               over_reg[ch]  <= 1'b0;
               under_reg[ch] <= 1'b0;
               cfg_reg[ch]   <= 1'b0;
            end
            else if (fn_s7 || fn_s5)
            begin
               cfg_reg[ch]   <= 1'b0;
               over_reg[ch]  <= (scaled > nom_hi);
               under_reg[ch] <= (scaled < 19'sd0);
               if (scaled > ovr_lim)
                  code_reg[ch] <= CODE_CLAMP_HI;
               else if (scaled < und_lim)
                  code_reg[ch] <= CODE_CLAMP_LO;
               else
                  code_reg[ch] <= scaled[15:0];
            end
            else
            begin
               // channel off or unknown code: no measurement
               code_reg[ch]  <= 16'h0000;
               over_reg[ch]  <= 1'b0;
               under_reg[ch] <= 1'b0;
               cfg_reg[ch]   <= (fn_reg[ch] != FN_CHAN_OFF);
            end
         end

         assign chan_code[ch]          = code_reg[ch];
         assign chan_function_code[ch] = fn_reg[ch];
         assign chan_err_led[ch]       = over_reg[ch] | under_reg[ch] | cfg_reg[ch];
      end
   endgenerate

   // summary and internal bytes
   always_comb
   begin
      summary = 8'h00;
      summary[SUM_MOD_FAIL] = module_fail;
      summary[SUM_INTERNAL] = diag_buf_overflow | int_comm_error;
      summary[SUM_EXTERNAL] = |(over_reg | under_reg);
      summary[SUM_CHANNEL]  = |(over_reg | under_reg | cfg_reg);
      summary[SUM_AUX]      = aux_supply_missing;
      summary[SUM_PARAM]    = |cfg_reg;
      intern = 8'h00;
      intern[INT_BUF_OVF] = diag_buf_overflow;
      intern[INT_COMM]    = int_comm_error;
   end

   assign module_err_led = |summary;

   // record image
   always_comb
   begin
      rec[BY_SUMMARY] = summary;
      rec[BY_MODINFO] = MODULE_INFO_VAL;
      rec[BY_RSVD]    = ERR_RESET;
      rec[BY_INTERN]  = intern;
      rec[BY_KIND]    = CHANNEL_KIND_VAL;
      rec[BY_NBITS]   = DIAG_BITS_VAL;
      rec[BY_NCHAN]   = CHANNEL_COUNT_VAL;
      rec[BY_CHSUM]   = {6'b000000, over_reg | under_reg | cfg_reg};
      for (int i = 0; i < NUM_CHAN; i++)
      begin
         rec[BY_CHERR0 + i]           = 8'h00;
         rec[BY_CHERR0 + i][CH_CFG]   = cfg_reg[i];
         rec[BY_CHERR0 + i][CH_UNDER] = under_reg[i];
         rec[BY_CHERR0 + i][CH_OVER]  = over_reg[i];
      end
      for (int i = BY_CHERR0 + NUM_CHAN; i < BY_STAMP; i++)
         rec[i] = ERR_RESET;
      for (int i = 0; i < 4; i++)
         rec[BY_STAMP + i] = stamp_reg[8*i +: 8];
   end

   // microsecond ticker and event stamp
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         us_div_reg   <= '0;
         us_count_reg <= 32'h00000000;
      end
      else if (us_div_reg == ($clog2(CYC_PER_US))'(CYC_PER_US - 1))
      begin
         us_div_reg   <= '0;
         us_count_reg <= us_count_reg + 32'h00000001;
      end
      else
         us_div_reg <= us_div_reg + 1'b1;
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         summary_prev_reg <= 8'h00;
         stamp_reg        <= 32'h00000000;
      end
      else
      begin
         summary_prev_reg <= summary;
         if (|(summary & ~summary_prev_reg))
            stamp_reg <= us_count_reg;
      end
   end

   // request decode and byte streaming
   logic                         busy_reg;
   logic [4:0]                   ptr_reg;
   logic [4:0]                   end_reg;
   logic                         rsp_valid_reg;
   logic                         rsp_last_reg;
   logic                         rsp_error_reg;
   logic [7:0]                   rsp_data_reg;
   logic                         rd_ok;
   logic [4:0]                   rd_first;
   logic [4:0]                   rd_last;
   logic                         wr_ok;
   logic [0:0]                   wr_chan;

   always_comb
   begin
      rd_ok    = 1'b0;
      rd_first = 5'd0;
      rd_last  = 5'(REC_BYTES - 1);
      wr_ok    = 1'b0;
      wr_chan  = 1'b0;
      case (link.req_access)
         ACC_RECORD:
         begin
            rd_ok   = (link.req_number == REC_DIAG_FULL) || (link.req_number == REC_DIAG_HEAD);
            rd_last = (link.req_number == REC_DIAG_HEAD) ? 5'(HEAD_BYTES - 1) : 5'(REC_BYTES - 1);
            wr_ok   = (link.req_number[15:1] == REC_FN_BASE[15:1]);
            wr_chan = link.req_number[0];
         end
         ACC_INDEX:
         begin
            rd_ok   = (link.req_number == IDX_DIAG_FULL) || (link.req_number == IDX_DIAG_HEAD);
            rd_last = (link.req_number == IDX_DIAG_HEAD) ? 5'(HEAD_BYTES - 1) : 5'(REC_BYTES - 1);
            wr_ok   = (link.req_number[15:1] == IDX_FN_BASE[15:1]);
            wr_chan = link.req_number[0];
         end
         ACC_SUBINDEX:
         begin
            if (link.req_number == IDX_DIAG_SUB)
            begin
               if (link.req_sub >= SUB_DIAG_BASE && link.req_sub <= SUB_DIAG_LAST)
               begin
                  rd_ok    = 1'b1;
                  rd_first = 5'(link.req_sub - SUB_DIAG_BASE);
                  rd_last  = rd_first;
               end
               else if (link.req_sub == SUB_STAMP)
               begin
                  rd_ok    = 1'b1;
                  rd_first = 5'(BY_STAMP);
               end
            end
            wr_ok   = (link.req_number == IDX_FN_BASE) &&
                      (link.req_sub == SUB_FN_BASE || link.req_sub == SUB_FN_BASE + 8'h01);
            wr_chan = 1'(link.req_sub - SUB_FN_BASE);
         end
         default:
            rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < NUM_CHAN; i++)
            fn_reg[i] <= FN_RESET;
      end
      else if (link.req_valid && !busy_reg && link.req_write && wr_ok)
         fn_reg[wr_chan] <= link.req_wdata;
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         busy_reg      <= 1'b0;
         ptr_reg       <= 5'd0;
         end_reg       <= 5'd0;
         rsp_valid_reg <= 1'b0;
         rsp_last_reg  <= 1'b0;
         rsp_error_reg <= 1'b0;
         rsp_data_reg  <= 8'h00;
      end
      else
      begin
         rsp_valid_reg <= 1'b0;
         rsp_last_reg  <= 1'b0;
         rsp_error_reg <= 1'b0;
         if (busy_reg)
         begin
            rsp_valid_reg <= 1'b1;
            rsp_data_reg  <= rec[ptr_reg];
            rsp_last_reg  <= (ptr_reg == end_reg);
            ptr_reg       <= ptr_reg + 5'd1;
            busy_reg      <= (ptr_reg != end_reg);
         end
         else if (link.req_valid)
         begin
            if (!link.req_write && rd_ok)
            begin
               busy_reg <= 1'b1;
               ptr_reg  <= rd_first;
               end_reg  <= rd_last;
            end
            else
            begin
               // write acknowledge or refusal
               rsp_valid_reg <= 1'b1;
               rsp_last_reg  <= 1'b1;
               rsp_data_reg  <= 8'h00;
               rsp_error_reg <= !(link.req_write && wr_ok);
            end
         end
      end
   end

   assign link.rsp_valid = rsp_valid_reg;
   assign link.rsp_data  = rsp_data_reg;
   assign link.rsp_last  = rsp_last_reg;
   assign link.rsp_error = rsp_error_reg;
endmodule // aidr_module
`default_nettype wire

// ===== core/aidr_pkg.sv
// constants and types for the analog input parameter / diagnostic records
// shared by the device end, the coupler end and the link interface
`default_nettype none
package aidr_pkg;
   localparam int CLK_MHZ = 100;
   localparam int US_NS   = 1000;
   localparam int CYC_PER_US = (US_NS * CLK_MHZ) / 1000;
   localparam int NUM_CHAN = 2;
   localparam int REC_BYTES = 20;
   localparam int HEAD_BYTES = 4;

   // function codes
   localparam logic [7:0] FN_S7_RANGE = 8'h10;
   localparam logic [7:0] FN_S5_RANGE = 8'h20;
   localparam logic [7:0] FN_CHAN_OFF = 8'hFF;
   localparam logic [7:0] FN_RESET    = 8'h10;

   // scaling: code = (mv * scale) >>> 16
   localparam logic [17:0] S7_SCALE = 18'h2C3CA;
   localparam logic [17:0] S5_SCALE = 18'h1A36F;
   localparam logic signed [15:0] S7_NOM_HI = 16'sh6C00;
   localparam logic signed [15:0] S7_OVR_LIM = 16'sh7EFF;
   localparam logic signed [15:0] S7_UND_LIM = 16'shED00;
   localparam logic signed [15:0] S5_NOM_HI = 16'sh4000;
   localparam logic signed [15:0] S5_OVR_LIM = 16'sh5000;
   localparam logic signed [15:0] S5_UND_LIM = 16'shF333;
   localparam logic [15:0] CODE_CLAMP_HI = 16'h7FFF;
   localparam logic [15:0] CODE_CLAMP_LO = 16'h8000;

   // access numbers
   localparam logic [15:0] REC_DIAG_FULL = 16'h0001;
   localparam logic [15:0] REC_DIAG_HEAD = 16'h0000;
   localparam logic [15:0] REC_FN_BASE   = 16'h0080;
   localparam logic [15:0] IDX_DIAG_FULL = 16'h2F01;
   localparam logic [15:0] IDX_DIAG_HEAD = 16'h2F00;
   localparam logic [15:0] IDX_FN_BASE   = 16'h3100;
   localparam logic [15:0] IDX_DIAG_SUB  = 16'h5005;
   localparam logic [7:0]  SUB_FN_BASE   = 8'h01;
   localparam logic [7:0]  SUB_DIAG_BASE = 8'h02;
   localparam logic [7:0]  SUB_DIAG_LAST = 8'h11;
   localparam logic [7:0]  SUB_STAMP     = 8'h13;

   // record byte positions
   localparam int BY_SUMMARY = 0;
   localparam int BY_MODINFO = 1;
   localparam int BY_RSVD    = 2;
   localparam int BY_INTERN  = 3;
   localparam int BY_KIND    = 4;
   localparam int BY_NBITS   = 5;
   localparam int BY_NCHAN   = 6;
   localparam int BY_CHSUM   = 7;
   localparam int BY_CHERR0  = 8;
   localparam int BY_STAMP   = 16;

   // constant bytes
   localparam logic [7:0] MODULE_INFO_VAL   = 8'h15;
   localparam logic [7:0] CHANNEL_KIND_VAL  = 8'h71;
   localparam logic [7:0] DIAG_BITS_VAL     = 8'h08;
   localparam logic [7:0] CHANNEL_COUNT_VAL = 8'h02;
   localparam logic [7:0] ERR_RESET         = 8'h00;

   // bit positions
   localparam int SUM_MOD_FAIL = 0;
   localparam int SUM_INTERNAL = 1;
   localparam int SUM_EXTERNAL = 2;
   localparam int SUM_CHANNEL  = 3;
   localparam int SUM_AUX      = 4;
   localparam int SUM_PARAM    = 7;
   localparam int INT_BUF_OVF  = 3;
   localparam int INT_COMM     = 4;
   localparam int CH_CFG       = 0;
   localparam int CH_UNDER     = 6;
   localparam int CH_OVER      = 7;

   typedef enum logic [1:0] {ACC_RECORD, ACC_INDEX, ACC_SUBINDEX} aidr_access_t;
   typedef enum logic [1:0] {OP_READ_FULL, OP_READ_HEAD, OP_READ_SUB, OP_WRITE_FN} aidr_op_t;
endpackage
`default_nettype wire

// ===== core/aidr_link_if.sv
// backplane link between the analog module and the bus coupler
// both ends run on the same core_clk; testbench joins them here
`timescale 1ns/1ps
`default_nettype none
interface aidr_link_if
   import aidr_pkg::*;
(
   input wire logic core_clk
);
   logic         req_valid;
   logic         req_write;
   aidr_access_t req_access;
   logic [15:0]  req_number;
   logic [7:0]   req_sub;
   logic [7:0]   req_wdata;
   logic         rsp_valid;
   logic [7:0]   rsp_data;
   logic         rsp_last;
   logic         rsp_error;

   modport dev (
      input  req_valid,
      input  req_write,
      input  req_access,
      input  req_number,
      input  req_sub,
      input  req_wdata,
      output rsp_valid,
      output rsp_data,
      output rsp_last,
      output rsp_error
   );
   modport cpl (
      output req_valid,
      output req_write,
      output req_access,
      output req_number,
      output req_sub,
      output req_wdata,
      input  rsp_valid,
      input  rsp_data,
      input  rsp_last,
      input  rsp_error
   );
endinterface
`default_nettype wire

// ===== core/aidr_coupler.sv
// bus coupler end: turns user commands into record, index or subindex requests
// assumes one command at a time; the module answers on the shared link
`timescale 1ns/1ps
`default_nettype none
module aidr_coupler
   import aidr_pkg::*;
(
   input  wire logic         core_clk,
   input  wire logic         rst,
   aidr_link_if.cpl          link,
   input  wire logic         cmd_valid,
   output logic              cmd_ready,
   input  wire aidr_op_t     cmd_op,
   input  wire aidr_access_t cmd_access,
   input  wire logic         cmd_chan,
   input  wire logic [7:0]   cmd_sub,
   input  wire logic [7:0]   cmd_wdata,
   output logic              rd_valid,
   output logic [7:0]        rd_data,
   output logic              done,
   output logic              done_error
);
   typedef enum logic {ST_IDLE, ST_WAIT} aidr_cpl_state_t;
   aidr_cpl_state_t state_reg;
   logic            req_valid_reg;
   logic            req_write_reg;
   aidr_access_t    req_access_reg;
   logic [15:0]     req_number_reg;
   logic [7:0]      req_sub_reg;
   logic [7:0]      req_wdata_reg;
   logic            rd_valid_reg;
   logic [7:0]      rd_data_reg;
   logic            done_reg;
   logic            done_error_reg;
   logic [15:0]     number_next;
   logic [7:0]      sub_next;

   // number and subindex for the chosen path
   always_comb
   begin
      number_next = REC_DIAG_FULL;
      sub_next    = 8'h00;
      case (cmd_op)
         OP_READ_FULL:
            number_next = (cmd_access == ACC_INDEX) ? IDX_DIAG_FULL : REC_DIAG_FULL;
         OP_READ_HEAD:
            number_next = (cmd_access == ACC_INDEX) ? IDX_DIAG_HEAD : REC_DIAG_HEAD;
         OP_READ_SUB:
         begin
            number_next = IDX_DIAG_SUB;
            sub_next    = cmd_sub;
         end
         OP_WRITE_FN:
         begin
            if (cmd_access == ACC_RECORD)
               number_next = REC_FN_BASE | {15'h0000, cmd_chan};
            else if (cmd_access == ACC_INDEX)
               number_next = IDX_FN_BASE | {15'h0000, cmd_chan};
            else
            begin
               number_next = IDX_FN_BASE;
               sub_next    = SUB_FN_BASE + {7'h00, cmd_chan};
            end
         end
         default:
            number_next = REC_DIAG_FULL;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg      <= ST_IDLE;
         req_valid_reg  <= 1'b0;
         req_write_reg  <= 1'b0;
         req_access_reg <= ACC_RECORD;
         req_number_reg <= 16'h0000;
         req_sub_reg    <= 8'h00;
         req_wdata_reg  <= 8'h00;
      end
      else
      begin
         req_valid_reg <= 1'b0;
         case (state_reg)
            ST_IDLE:
               if (cmd_valid)
               begin
                  req_valid_reg  <= 1'b1;
                  req_write_reg  <= (cmd_op == OP_WRITE_FN);
                  req_access_reg <= (cmd_op == OP_READ_SUB) ? ACC_SUBINDEX : cmd_access;
                  req_number_reg <= number_next;
                  req_sub_reg    <= sub_next;
                  req_wdata_reg  <= cmd_wdata;
                  state_reg      <= ST_WAIT;
               end
            ST_WAIT:
               if (link.rsp_valid && link.rsp_last)
                  state_reg <= ST_IDLE;
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         rd_valid_reg   <= 1'b0;
         rd_data_reg    <= 8'h00;
         done_reg       <= 1'b0;
         done_error_reg <= 1'b0;
      end
      else
      begin
         rd_valid_reg <= link.rsp_valid && !req_write_reg && !link.rsp_error;
         done_reg     <= link.rsp_valid && link.rsp_last && (state_reg == ST_WAIT);
         if (link.rsp_valid)
            rd_data_reg <= link.rsp_data;
         if (link.rsp_valid && link.rsp_last)
            done_error_reg <= link.rsp_error;
      end
   end

   assign cmd_ready       = (state_reg == ST_IDLE);
   assign link.req_valid  = req_valid_reg;
   assign link.req_write  = req_write_reg;
   assign link.req_access = req_access_reg;
   assign link.req_number = req_number_reg;
   assign link.req_sub    = req_sub_reg;
   assign link.req_wdata  = req_wdata_reg;
   assign rd_valid        = rd_valid_reg;
   assign rd_data         = rd_data_reg;
   assign done            = done_reg;
   assign done_error      = done_error_reg;
endmodule // aidr_coupler
`default_nettype wire

// ===== verif/aidr_link_monitor.sv
// link checker: answer timing and fixed record bytes
// assumes one core_clk domain, rst async active high
`timescale 1ns/1ps
`default_nettype none
module aidr_link_monitor
   import aidr_pkg::*;
(
   input wire logic         core_clk,
   input wire logic         rst,
   input wire logic         req_valid,
   input wire logic         req_write,
   input wire aidr_access_t req_access,
   input wire logic [15:0]  req_number,
   input wire logic [7:0]   req_sub,
   input wire logic [7:0]   req_wdata,
   input wire logic         rsp_valid,
   input wire logic [7:0]   rsp_data,
   input wire logic         rsp_last,
   input wire logic         rsp_error
);
   logic rd, rec_full, rec_head, idx_full, idx_head;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (rst);
   assign rd = req_valid && !req_write;
   assign rec_full = rd && req_access == ACC_RECORD && req_number == 16'h0001;
   assign rec_head = rd && req_access == ACC_RECORD && req_number == 16'h0000;
   assign idx_full = rd && req_access == ACC_INDEX && req_number == 16'h2F01;
   assign idx_head = rd && req_access == ACC_INDEX && req_number == 16'h2F00;
   chk_rec_full_len: assert property (rec_full |-> ##21 rsp_valid && rsp_last)
      else $error("full rec len");
   chk_rec_head_len: assert property (rec_head |-> ##5 rsp_valid && rsp_last)
      else $error("head rec len");
   chk_error_last: assert property (rsp_error |-> rsp_valid && rsp_last)
      else $error("error without last");
   chk_idx_full_len: assert property (idx_full |-> ##21 rsp_valid && rsp_last)
      else $error("full idx len");
   chk_idx_head_len: assert property (idx_head |-> ##2 !rsp_last [*3] ##1 rsp_last)
      else $error("head idx len");
   chk_stream_steady: assert property (rec_full |-> ##2 (rsp_valid && !rsp_last) [*8])
      else $error("stream gap");
   chk_modinfo_byte: assert property (rec_full |-> ##3 rsp_data == 8'h15)
      else $error("modinfo byte");
   chk_descr_bytes: assert property (rec_full |-> ##6 rsp_data == 8'h71 ##1 rsp_data == 8'h08
      ##1 rsp_data == 8'h02)
      else $error("descriptor bytes");
   chk_sub_byte: assert property (rd && req_access == ACC_SUBINDEX && req_sub == 8'h03
      |-> ##2 rsp_valid && rsp_last && rsp_data == 8'h15)
      else $error("sub byte");
   chk_write_ack: assert property (req_valid && req_write |-> ##1 rsp_valid && rsp_last)
      else $error("write ack");
   cov_full: cover property (rec_full ##21 rsp_last);
   cov_head: cover property (idx_head ##5 rsp_last);
   cov_write: cover property (req_valid && req_write && req_wdata == 8'h55);
endmodule // aidr_link_monitor
`default_nettype wire

// ===== verif/testbench.sv
// self-checking bench: coupler and module joined over the link
// assumes both ends share core_clk and rst
`timescale 1ns/1ps
`default_nettype none
module testbench
   import aidr_pkg::*;
;
   logic               core_clk;
   logic               rst = 1'b1;
   logic               cmd_valid = 1'b0;
   logic               cmd_chan = 1'b0;
   logic [7:0]         cmd_sub = 8'h00;
   logic [7:0]         cmd_wdata = 8'h00;
   aidr_op_t           cmd_op = OP_READ_FULL;
   aidr_access_t       cmd_access = ACC_RECORD;
   logic [3:0]         flt = 4'h0;
   logic signed [15:0] volt_mv [NUM_CHAN] = '{16'sh0000, 16'sh2710};
   logic [15:0]        chan_code [NUM_CHAN];
   logic [7:0]         chan_function_code [NUM_CHAN];
   logic [1:0]         chan_err_led;
   logic               module_err_led, cmd_ready, rd_valid, done, done_error;
   logic [7:0]         rd_data;
   logic [7:0]         got [$];
   logic [7:0]         img [20] = '{1: 8'h15, 4: 8'h71, 5: 8'h08, 6: 8'h02, default: 8'h00};
   int                 bad_count = 0;
   int                 tests_run = 0;
   aidr_link_if lk (.core_clk(core_clk));
   aidr_module u_aidr_module (.core_clk(core_clk), .rst(rst), .link(lk),
      .volt_mv(volt_mv), .module_fail(flt[0]), .aux_supply_missing(flt[1]),
      .diag_buf_overflow(flt[2]), .int_comm_error(flt[3]), .chan_code(chan_code),
      .chan_function_code(chan_function_code), .chan_err_led(chan_err_led),
      .module_err_led(module_err_led));
   aidr_coupler u_aidr_coupler (.core_clk(core_clk), .rst(rst), .link(lk),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_access(cmd_access),
      .cmd_chan(cmd_chan), .cmd_sub(cmd_sub), .cmd_wdata(cmd_wdata), .rd_valid(rd_valid),
      .rd_data(rd_data), .done(done), .done_error(done_error));
   aidr_link_monitor u_aidr_link_monitor (.core_clk(core_clk), .rst(rst),
      .req_valid(lk.req_valid), .req_write(lk.req_write),
      .req_access(lk.req_access), .req_number(lk.req_number),
      .req_sub(lk.req_sub), .req_wdata(lk.req_wdata),
      .rsp_valid(lk.rsp_valid), .rsp_data(lk.rsp_data),
      .rsp_last(lk.rsp_last), .rsp_error(lk.rsp_error));
   task automatic check(input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // one command; bytes into got
   task automatic run(input aidr_op_t op, input aidr_access_t acc,
      input logic [7:0] sub, input logic [7:0] wd);
      int n = 0;
      got = {};
      @(negedge core_clk);
      cmd_op = op;
      cmd_access = acc;
      cmd_sub = sub;
      cmd_chan = sub[0];
      cmd_wdata = wd;
      cmd_valid = 1'b1;
      @(negedge core_clk);
      cmd_valid = 1'b0;
      n = 0;
      while (n < 60)
      begin
         @(posedge core_clk);
         #1;
         if (rd_valid === 1'b1)
            got.push_back(rd_data);
         if (done === 1'b1)
            break;
         n++;
      end
      check(n < 60, 1'b1);
   endtask
   task automatic full;
      run(OP_READ_FULL, ACC_RECORD, 8'h00, 8'h00);
      check(got.size(), 20);
   endtask
   task automatic t_reset;
      check(chan_function_code[0], 8'h10);
      check(chan_function_code[1], 8'h10);
      full();
      foreach (img[i])
         check(got[i], img[i]);
      $display("test reset done");
   endtask
   task automatic t_access;
      for (int i = 0; i < 2; i++)
      begin
         run(OP_READ_HEAD, aidr_access_t'(i), 8'h00, 8'h00);
         check(got.size(), 4);
         check(got[1], 8'h15);
         run(OP_READ_FULL, aidr_access_t'(i), 8'h00, 8'h00);
         check(got.size(), 20);
      end
      for (int s = 2; s < 18; s++)
      begin
         run(OP_READ_SUB, ACC_SUBINDEX, 8'(s), 8'h00);
         check(got.size(), 1);
         check(got[0], img[s-2]);
      end
      run(OP_READ_SUB, ACC_SUBINDEX, 8'h13, 8'h00);
      check(got.size(), 4);
      $display("test access done");
   endtask
   task automatic t_range;
      // fn, mV, code, chan byte, summary, chan summary
      logic [63:0] tab [6] = '{64'h10_2710_6C00_00_00_00, 64'h20_2710_4000_00_00_00,
         64'h20_30D4_5000_80_0C_01, 64'h20_F830_F333_40_0C_01,
         64'h20_4E20_7FFF_80_0C_01, 64'h10_EC78_8000_40_0C_01};
      for (int i = 0; i < 7; i++)
      begin
         run(OP_WRITE_FN, ACC_RECORD, 8'h00, i < 6 ? tab[i][63:56] : 8'h10);
         @(negedge core_clk);
         volt_mv[0] = i < 6 ? tab[i][55:40] : 16'h0000;
         repeat (2) @(posedge core_clk);
         #1;
         if (i == 6)
            break;
         check(chan_code[0], tab[i][39:24]);
         check(chan_err_led[0], |tab[i][23:16]);
         full();
         check(got[8], tab[i][23:16]);
         check(got[0], tab[i][15:8]);
         check(got[7], tab[i][7:0]);
      end
      $display("test range done");
   endtask
   task automatic t_fn;
      logic [7:0] wd [3] = '{8'hFF, 8'h55, 8'h20};
      foreach (wd[i])
      begin
         run(OP_WRITE_FN, aidr_access_t'(i), 8'h01, wd[i]);
         check(done_error, 1'b0);
         check(chan_function_code[1], wd[i]);
         full();
         check(chan_code[1], i == 2 ? 16'h4000 : 16'h0000);
         check(got[9], {7'h00, i == 1});
         check(got[0], i == 1 ? 8'h88 : 8'h00);
         check(got[7], {6'h00, i == 1, 1'b0});
      end
      $display("test function done");
   endtask
   task automatic t_faults;
      logic [15:0] ft [4] = '{16'h0100, 16'h1000, 16'h0208, 16'h0210};
      logic [31:0] ts;
      ts = {got[19], got[18], got[17], got[16]};
      foreach (ft[i])
      begin
         @(negedge core_clk);
         flt = 4'h0;
         repeat (110) @(negedge core_clk);
         flt = 4'h1 << i;
         full();
         check(got[0], ft[i][15:8]);
         check(got[3], ft[i][7:0]);
         check(module_err_led, 1'b1);
         check({got[19], got[18], got[17], got[16]} != ts, 1'b1);
         ts = {got[19], got[18], got[17], got[16]};
      end
      @(negedge core_clk);
      flt = 4'h0;
      $display("test faults done");
   endtask
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial
   begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      report_and_stop();
   end
   initial
   begin
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      t_reset();
      t_access();
      t_range();
      t_fn();
      t_faults();
      report_and_stop();
   end
endmodule // testbench
`default_nettype wire
